// [shared/tmp_fields_pkg.sv]
package tmp_fields_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CFG0 = 12'h004;
  localparam logic [11:0] ADDR_CFG1 = 12'h008;
  localparam logic [11:0] ADDR_CFG2 = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [2:0] EMIT_PAGE = 3'h1;
  localparam logic [2:0] XMTR_PAGE = 3'h2;
  localparam int CTRL_START = 0;
  localparam int CTRL_OVERRIDE = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ORDER_ERR = 1;
  localparam int STAT_GROUP = 8;
  localparam logic [3:0] VERSION_MINOR = 4'h0;
  localparam logic [2:0] OVERRIDE_ON = 3'h7;
  localparam logic [2:0] OVERRIDE_OFF = 3'h0;
  localparam logic [1:0] SHIFT_RESERVED = 2'h2;
  localparam logic [31:0] NS_LIMIT = 32'h3b9ac9ff;
  localparam logic [6:0] PAYLOAD_TYPE = 7'h4c;
  localparam logic [15:0] LEN_FIXED = 16'h0020;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [3:0] HDR_BYTES = 4'hc;
  localparam logic [3:0] ENTRY_BYTES = 4'h8;
  localparam logic [3:0] TAIL_BYTES = 4'h2;

  typedef struct packed {
    logic [15:0] length;
    logic [3:0] verMajor;
    logic [3:0] verMinor;
    logic [3:0] repPre;
    logic [3:0] repTim;
    logic [3:0] syncRoot;
    logic [3:0] syncSeed;
    logic [4:0] minTimeNext;
    logic [1:0] bandwidth;
    logic [6:0] bsrCoef;
    logic [7:0] preambleStruct;
    logic [1:0] emergencyAlertWakeBits;
    logic [5:0] emitCountM1;
    logic [5:0] groupSizeM1;
    logic [6:0] groupIndex;
    logic [2:0] override;
    logic [1:0] filtCodeCount;
    logic [1:0] carrierShift;
    logic [5:0] rsv;
  } hdr_t;

  typedef struct packed {
    logic [12:0] stationAddress;
    logic [15:0] delayAdjust;
    logic [3:0] identSignalLevel;
    logic [1:0] filterSlot;
    logic [28:0] rsv;
  } xmtr_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_HDR = 6'b000010,
    S_EMIT = 6'b000100,
    S_XMTR = 6'b001000,
    S_REL = 6'b010000,
    S_CHK = 6'b100000
  } state_t;
endpackage : tmp_fields_pkg

// [verif/byte_sink_model.sv]
`timescale 1ns/1ps
module byte_sink_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slow,
  input wire logic [7:0] byteData,
  input wire logic byteValid,
  input wire logic byteFirst,
  output logic byteReady
);
  // plain default rate, only scales the offset figure
  localparam int SAMPLE_RATE = 8192000;
  logic [7:0] mem [0:2047];
  logic stall;
  int count;
  int pos;
  int cur;
  int xStart;
  int offsetHz;
  logic [3:0] rootSel;
  logic [3:0] seedSel;
  logic [1:0] wakeBits;
  logic [1:0] shiftSel;
  logic [5:0] emitCnt;
  logic [3:0] levelCode;
  logic identOff;
  wire take = byteValid && byteReady;
  // slow mode refuses every other cycle, so each byte must be held
  assign byteReady = !(slow && stall);
  assign cur = byteFirst ? 0 : pos;
  // transmitter loop begins after header and emission entries
  assign xStart = 12 + 8 * (int'(emitCnt) + 1);
  assign offsetHz = int'(signed'(shiftSel)) * SAMPLE_RATE / 8192;
  assign identOff = levelCode == 4'h0;
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      stall <= 1'b0;
      count <= 0;
      pos <= 0;
    end
    else
    begin
      stall <= ~stall;
      if (take)
      begin
        mem[count] <= byteData;
        count <= count + 1;
        pos <= cur + 1;
        if (cur == 4)
        begin
          rootSel <= byteData[7:4];
          seedSel <= byteData[3:0];
        end
        if (cur == 7)
          wakeBits <= byteData[1:0];
        if (cur == 8)
          emitCnt <= byteData[7:2];
        if (cur == 11)
          shiftSel <= byteData[7:6];
        // first transmitter level straddles two bytes
        if (cur == xStart + 3)
          levelCode[3:1] <= byteData[2:0];
        if (cur == xStart + 4)
          levelCode[0] <= byteData[7];
      end
    end
  end
endmodule : byte_sink_model

// [verif/timing_mgmt_packet_fields_bench.sv]
`timescale 1ns/1ps
module timing_mgmt_packet_fields_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] taiSeconds = 32'h12345678;
  logic [31:0] taiNanos = 32'h3b9ac9ff;
  logic slow = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] byteData;
  logic byteValid;
  logic byteFirst;
  logic byteLast;
  logic byteReady;
  logic [6:0] payloadType;
  logic busy;
  logic [31:0] rdat;
  logic [7:0] expB [$];
  tmp_fields_pkg::hdr_t hdr;
  int nFail = 0;
  int checks = 0;
  int cycles = 0;
  int base;

  timing_mgmt_packet_framer uut (.clk_sys, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .taiSeconds, .taiNanos, .byteData, .byteValid, .byteFirst, .byteLast, .byteReady,
    .payloadType, .busy);
  byte_sink_model sink (.clk_sys, .resetn, .slow, .byteData, .byteValid, .byteFirst, .byteReady);

  initial
    forever #5 clk_sys = ~clk_sys;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic e);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // this wait ends as soon as pready is high; the bench timeout catches a hang
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rdat = prdata;
    check("pslverr", {31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic push(input logic [63:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--)
      expB.push_back(v[8*i +: 8]);
  endtask : push

  // reference check word, worked bit by bit apart from the design
  function automatic logic [15:0] crcOf();
    logic [15:0] c;
    c = tmp_fields_pkg::CRC_INIT;
    foreach (expB[i])
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ expB[i][b]) ? tmp_fields_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction : crcOf

  // a hang counts as a failure
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      nFail++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(tmp_fields_pkg::ADDR_CFG0, 1'b0, 32'h0, 1'b0);
    check("cfg0", rdat, 32'h00000110);
    for (int v = 0; v < 11; v++)
    begin
      apb(tmp_fields_pkg::ADDR_CFG0, 1'b1, 32'h100 | (v << 4), !(v inside {1, 3, 5, 7, 9}));
      apb(tmp_fields_pkg::ADDR_CFG0, 1'b1, 32'h010 | (v << 8), !(v inside {1, 3, 5, 7, 9}));
    end
    apb(tmp_fields_pkg::ADDR_CFG2, 1'b1, 32'h00000001, 1'b1);
    apb(tmp_fields_pkg::ADDR_CFG2, 1'b1, 32'h00000481, 1'b1);
    apb(tmp_fields_pkg::ADDR_CFG2, 1'b0, 32'h0, 1'b0);
    check("cfg2", rdat, 32'h00000080);
    apb(12'h100, 1'b1, 32'h0, 1'b1);
    apb(12'h204, 1'b1, 32'h3b9aca00, 1'b1);
    apb(12'h40c, 1'b1, 32'h00000053, 1'b1);
    apb(tmp_fields_pkg::ADDR_CFG0, 1'b1, 32'h02512530, 1'b0);
    apb(tmp_fields_pkg::ADDR_CFG1, 1'b1, 32'h00838902, 1'b0);
    apb(tmp_fields_pkg::ADDR_CFG2, 1'b1, 32'h00000681, 1'b0);
    apb(12'h200, 1'b1, 32'h00000064, 1'b0);
    apb(12'h204, 1'b1, 32'h00000005, 1'b0);
    apb(12'h208, 1'b1, 32'h00000064, 1'b0);
    apb(12'h20c, 1'b1, 32'h3b9ac9ff, 1'b0);
    apb(12'h400, 1'b1, 32'h10001fff, 1'b0);
    apb(12'h404, 1'b1, 32'h00000040, 1'b0);
    apb(12'h408, 1'b1, 32'h0fffe005, 1'b0);
    apb(12'h40c, 1'b1, 32'h00000013, 1'b0);
    apb(12'h404, 1'b0, 32'h0, 1'b0);
    check("code", rdat, 32'h00000040);
    // three packets: group wraps after the middle one, override in the middle one
    for (int p = 0; p < 3; p++)
    begin
      slow <= p[0];
      hdr = '{16'h0030, 4'h0, 4'h0, 4'h3, 4'h5, 4'h2, 4'h1, 5'h05, 2'h1, 7'h02, 8'h12, 2'h3, 6'h01, 6'h01,
        7'(p % 2), (p == 1) ? 3'h7 : 3'h0, 2'h1, 2'h3, 6'h3f};
      expB.delete();
      push(hdr[95:32], 8);
      push({32'h0, hdr[31:0]}, 4);
      push({32'h00000064, 32'h00000005}, 8);
      push({32'h00000064, 32'h3b9ac9ff}, 8);
      push({13'h1fff, 16'h8000, 4'h0, 2'h3, 29'h1fffffff}, 8);
      push({13'h0005, 16'h7fff, 4'h3, 2'h0, 29'h1fffffff}, 8);
      push({48'h0, 4'h8, 10'h3b9, 2'h3}, 2);
      push({48'h0, crcOf()}, 2);
      base = sink.count;
      // override settles before the start write freezes the header
      apb(tmp_fields_pkg::ADDR_CTRL, 1'b1, (p == 1) ? 32'h2 : 32'h0, 1'b0);
      apb(tmp_fields_pkg::ADDR_CTRL, 1'b1, (p == 1) ? 32'h3 : 32'h1, 1'b0);
      apb(tmp_fields_pkg::ADDR_STATUS, 1'b0, 32'h0, 1'b0);
      check("busy", rdat[0], 1'b1);
      if (p == 1)
        apb(tmp_fields_pkg::ADDR_CTRL, 1'b1, 32'h3, 1'b0);
      while (busy !== 1'b0)
        @(posedge clk_sys);
      apb(tmp_fields_pkg::ADDR_STATUS, 1'b0, 32'h0, 1'b0);
      check("group", rdat[14:8], 7'((p + 1) % 2));
      check("count", sink.count - base, expB.size());
      foreach (expB[i])
        check("byte", sink.mem[base + i], expB[i]);
      check("root", sink.rootSel, 4'h2);
      check("seed", sink.seedSel, 4'h1);
      check("wake", sink.wakeBits, 2'h3);
      check("offset", sink.offsetHz, 32'hfffffc18);
      check("ident", sink.identOff, 1'b1);
    end
    apb(12'h208, 1'b1, 32'h00000063, 1'b0);
    apb(tmp_fields_pkg::ADDR_CTRL, 1'b1, 32'h1, 1'b0);
    check("busy", busy, 1'b0);
    apb(tmp_fields_pkg::ADDR_STATUS, 1'b0, 32'h0, 1'b0);
    check("order", rdat[1:0], 2'h2);
    apb(tmp_fields_pkg::ADDR_STATUS, 1'b1, 32'h2, 1'b1);
    apb(tmp_fields_pkg::ADDR_STATUS, 1'b0, 32'h0, 1'b0);
    check("order", rdat[1], 1'b0);
    complete_run();
  end
endmodule : timing_mgmt_packet_fields_bench

// [verif/timing_mgmt_packet_properties.sv]
`timescale 1ns/1ps
module timing_mgmt_packet_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic [7:0] byteData,
  input wire logic byteValid,
  input wire logic byteFirst,
  input wire logic byteLast,
  input wire logic byteReady,
  input wire logic [6:0] payloadType,
  input wire logic busy
);
  logic [10:0] idx;
  logic [15:0] lenSeen;
  wire take = byteValid && byteReady;
  wire wr = psel && penable && pwrite;
  wire cfg0 = wr && paddr == tmp_fields_pkg::ADDR_CFG0;
  wire cfg2 = wr && paddr == tmp_fields_pkg::ADDR_CFG2;
  wire nsWord = wr && paddr[11:9] == tmp_fields_pkg::EMIT_PAGE && paddr[2:0] == 3'h4;
  function automatic logic oddRep(input logic [3:0] v);
    return v inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h9};
  endfunction : oddRep
  // byte position inside the packet, so header fields can be picked off the wire
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || (take && byteLast))
      idx <= 11'h000;
    else if (take)
      idx <= idx + 11'h001;
  end
  always_ff @(posedge clk_sys)
  begin
    if (take && idx == 11'h000)
      lenSeen[15:8] <= byteData;
    if (take && idx == 11'h001)
      lenSeen[7:0] <= byteData;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  minor_zero_a: assert property (
    byteValid && idx == 11'h002 |-> byteData[3:0] == tmp_fields_pkg::VERSION_MINOR) else $error("minor nonzero");
  pre_refused_a: assert property (
    cfg0 && !oddRep(pwdata[7:4]) |-> pslverr) else $error("bad preamble repeat taken");
  tim_refused_a: assert property (
    cfg0 && !oddRep(pwdata[11:8]) |-> pslverr) else $error("bad timing repeat taken");
  filt_refused_a: assert property (
    cfg2 && pwdata[8:7] == 2'h0 |-> pslverr) else $error("filter count zero taken");
  shift_refused_a: assert property (
    cfg2 && pwdata[10:9] == tmp_fields_pkg::SHIFT_RESERVED |-> pslverr) else $error("shift -2 taken");
  ns_refused_a: assert property (
    nsWord && pwdata > tmp_fields_pkg::NS_LIMIT |-> pslverr) else $error("ns word too large taken");
  override_code_a: assert property (
    byteValid && idx == 11'h00a |-> byteData[4:2] inside {3'h0, 3'h7} && byteData[1:0] != 2'h0)
    else $error("override or filter count bad");
  tail_bits_a: assert property (
    byteValid && idx == 11'h00b |-> byteData[5:0] == 6'h3f && byteData[7:6] != 2'h2) else $error("reserved bits");
  hold_byte_a: assert property (
    byteValid && !byteReady |=> byteValid && $stable(byteData) && $stable(byteLast)) else $error("byte dropped");
  first_byte_a: assert property (
    $rose(busy) |=> byteValid && byteFirst && idx == 11'h000) else $error("first byte late");
  length_match_a: assert property (
    take && byteLast |-> {5'h00, idx} + 16'h0001 == lenSeen) else $error("length field wrong");
  packet_end_a: assert property (
    take && byteLast |=> !busy && !byteValid) else $error("packet did not end");
  ptype_value_a: assert property (
    $past(resetn) |-> payloadType == tmp_fields_pkg::PAYLOAD_TYPE) else $error("payload type wrong");
  cover property (take && byteLast);
  cover property (cfg0 && pslverr);
  cover property (byteValid && !byteReady);
endmodule : timing_mgmt_packet_properties

bind timing_mgmt_packet_framer timing_mgmt_packet_properties chk (.clk_sys, .resetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pslverr, .byteData, .byteValid, .byteFirst, .byteLast, .byteReady, .payloadType, .busy);

// [verilog/payload_check_crc.sv]
`timescale 1ns/1ps
module payload_check_crc (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clear,
  input wire logic enable,
  input wire logic [7:0] dataIn,
  output logic [15:0] crc
);
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      r = r[15] ? ((r << 1) ^ tmp_fields_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crcByte

  always_ff @(posedge clk_sys)
  begin
    if (!resetn || clear)
      crc <= tmp_fields_pkg::CRC_INIT;
    else if (enable)
      crc <= crcByte(crc, dataIn);
  end
endmodule : payload_check_crc

// [verilog/timing_mgmt_packet_framer.sv]
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module timing_mgmt_packet_framer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] taiSeconds,
  input wire logic [31:0] taiNanos,
  output logic [7:0] byteData,
  output logic byteValid,
  output logic byteFirst,
  output logic byteLast,
  input wire logic byteReady,
  output logic [6:0] payloadType,
  output logic busy
);
  // configuration and status
  logic override;
  logic [3:0] verMajor;
  logic [3:0] repPre;
  logic [3:0] repTim;
  logic [3:0] syncRoot;
  logic [3:0] syncSeed;
  logic [4:0] minTimeNext;
  logic [1:0] bandwidth;
  logic [6:0] bsrCoef;
  logic [7:0] preambleStruct;
  logic [1:0] emergencyAlertWakeBits;
  logic [5:0] emitCountM1;
  logic [5:0] groupSizeM1;
  logic [6:0] groupLast;
  logic [1:0] filtCodeCount;
  logic [1:0] carrierShift;
  logic orderErr;
  logic [6:0] groupIndex;
  // tables live in flops; software must not rewrite them while busy
  logic [31:0] emitSec [64];
  logic [31:0] emitNs [64];
  logic [12:0] xAddr [64];
  logic [15:0] xDelay [64];
  logic [3:0] xLevel [64];
  logic [1:0] xSlot [64];

  // framing state
  tmp_fields_pkg::state_t state;
  tmp_fields_pkg::hdr_t hdr;
  logic [3:0] byteIdx;
  logic [5:0] entryIdx;
  logic [3:0] relSec;
  logic [9:0] relSub;
  logic firstPending;
  logic [15:0] payloadCheckWord;

  function automatic logic repOk(input logic [3:0] v);
    return v[0] && (v <= 4'h9);
  endfunction : repOk

  function automatic logic [7:0] topByte(input logic [95:0] w, input logic [3:0] idx);
    logic [95:0] s;
    s = w << {idx, 3'b000};
    return s[95:88];
  endfunction : topByte

  // bus decode
  wire access = psel && penable;
  wire aligned = paddr[1:0] == 2'b00;
  wire isCtrl = aligned && paddr == tmp_fields_pkg::ADDR_CTRL;
  wire isCfg0 = aligned && paddr == tmp_fields_pkg::ADDR_CFG0;
  wire isCfg1 = aligned && paddr == tmp_fields_pkg::ADDR_CFG1;
  wire isCfg2 = aligned && paddr == tmp_fields_pkg::ADDR_CFG2;
  wire isStat = aligned && paddr == tmp_fields_pkg::ADDR_STATUS;
  wire isEmit = aligned && paddr[11:9] == tmp_fields_pkg::EMIT_PAGE;
  wire isXmtr = aligned && paddr[11:9] == tmp_fields_pkg::XMTR_PAGE;
  wire [5:0] tabIdx = paddr[8:3];
  wire hiWord = paddr[2];
  wire mapped = isCtrl || isCfg0 || isCfg1 || isCfg2 || isStat || isEmit || isXmtr;

  wire cfg0Ok = repOk(pwdata[7:4]) && repOk(pwdata[11:8]);
  wire cfg2Ok = pwdata[8:7] != 2'b00 && pwdata[10:9] != tmp_fields_pkg::SHIFT_RESERVED;
  wire nsOk = pwdata <= tmp_fields_pkg::NS_LIMIT;
  wire codeOk = pwdata[6:4] != 3'h0 && pwdata[6:4] <= 3'h4;
  wire valueOk = (isCfg0 ? cfg0Ok : 1'b1) && (isCfg2 ? cfg2Ok : 1'b1) &&
    ((isEmit && hiWord) ? nsOk : 1'b1) && ((isXmtr && hiWord) ? codeOk : 1'b1);
  wire badWrite = pwrite && (isStat || !valueOk);
  wire wrEn = access && pwrite && mapped && !badWrite;
  wire startReq = wrEn && isCtrl && pwdata[tmp_fields_pkg::CTRL_START];
  wire errClear = access && pwrite && isStat && pwdata[tmp_fields_pkg::STAT_ORDER_ERR];

  assign pready = 1'b1;
  assign pslverr = access && (!mapped || badWrite);

  wire [31:0] ctrlRd = {30'h0, override, 1'b0};
  wire [31:0] cfg0Rd = {5'h0, bandwidth, minTimeNext, syncSeed, syncRoot, repTim, repPre, verMajor};
  wire [31:0] cfg1Rd = {3'h0, groupSizeM1, emitCountM1, emergencyAlertWakeBits, preambleStruct, bsrCoef};
  wire [31:0] cfg2Rd = {21'h0, carrierShift, filtCodeCount, groupLast};
  wire [31:0] statRd = {17'h0, groupIndex, 6'h0, orderErr, busy};
  wire [31:0] emitRd = hiWord ? emitNs[tabIdx] : emitSec[tabIdx];
  wire [31:0] xLoRd = {3'h0, xDelay[tabIdx], xAddr[tabIdx]};
  wire [31:0] xHiRd = {25'h0, 1'b0, xSlot[tabIdx] + 2'h1, xLevel[tabIdx]};
  wire [31:0] xRd = hiWord ? ((xSlot[tabIdx] == 2'h3) ? {25'h0, 3'h4, xLevel[tabIdx]} : xHiRd) : xLoRd;
  wire [31:0] nextRd = isCtrl ? ctrlRd : isCfg0 ? cfg0Rd : isCfg1 ? cfg1Rd : isCfg2 ? cfg2Rd :
    isStat ? statRd : isEmit ? emitRd : isXmtr ? xRd : 32'h0;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= nextRd;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      override <= 1'b0;
      {bandwidth, minTimeNext, syncSeed, syncRoot, repTim, repPre, verMajor} <= 27'h0000110;
      {groupSizeM1, emitCountM1, emergencyAlertWakeBits, preambleStruct, bsrCoef} <= 29'h0;
      {carrierShift, filtCodeCount, groupLast} <= 11'h080;
    end
    else if (wrEn)
    begin
      if (isCtrl)
        override <= pwdata[tmp_fields_pkg::CTRL_OVERRIDE];
      if (isCfg0)
        {bandwidth, minTimeNext, syncSeed, syncRoot, repTim, repPre, verMajor} <= pwdata[26:0];
      if (isCfg1)
        {groupSizeM1, emitCountM1, emergencyAlertWakeBits, preambleStruct, bsrCoef} <= pwdata[28:0];
      if (isCfg2)
        {carrierShift, filtCodeCount, groupLast} <= pwdata[10:0];
    end
  end

  // tables carry no reset: contents are data, not control
  always_ff @(posedge clk_sys)
  begin
    if (wrEn && isEmit && !hiWord)
      emitSec[tabIdx] <= pwdata;
    if (wrEn && isEmit && hiWord)
      emitNs[tabIdx] <= pwdata;
    if (wrEn && isXmtr && !hiWord)
      {xDelay[tabIdx], xAddr[tabIdx]} <= pwdata[28:0];
    if (wrEn && isXmtr && hiWord)
      {xSlot[tabIdx], xLevel[tabIdx]} <= {2'(pwdata[6:4] - 3'h1), pwdata[3:0]};
  end

  logic orderBad;
  always_comb
  begin
    orderBad = 1'b0;
    for (int i = 1; i < 64; i++)
    begin
      if (6'(i) <= emitCountM1 && {emitSec[i], emitNs[i]} <= {emitSec[i - 1], emitNs[i - 1]})
        orderBad = 1'b1;
    end
  end

  wire isIdle = state == tmp_fields_pkg::S_IDLE;
  wire launch = startReq && isIdle && !orderBad;
  wire orderSet = startReq && isIdle && orderBad;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      orderErr <= 1'b0;
    else if (orderSet)
      orderErr <= 1'b1;
    else if (errClear)
      orderErr <= 1'b0;
  end

  // payload bytes: 12 header + 8 per entry + 2 release + 2 check
  wire [15:0] lengthNow = tmp_fields_pkg::LEN_FIXED + {7'h0, emitCountM1, 3'b000} + {7'h0, groupSizeM1, 3'b000};
  tmp_fields_pkg::hdr_t hdrNow;
  always_comb
  begin
    hdrNow.length = lengthNow;
    hdrNow.verMajor = verMajor;
    hdrNow.verMinor = tmp_fields_pkg::VERSION_MINOR;
    hdrNow.repPre = repPre;
    hdrNow.repTim = repTim;
    hdrNow.syncRoot = syncRoot;
    hdrNow.syncSeed = syncSeed;
    hdrNow.minTimeNext = minTimeNext;
    hdrNow.bandwidth = bandwidth;
    hdrNow.bsrCoef = bsrCoef;
    hdrNow.preambleStruct = preambleStruct;
    hdrNow.emergencyAlertWakeBits = emergencyAlertWakeBits;
    hdrNow.emitCountM1 = emitCountM1;
    hdrNow.groupSizeM1 = groupSizeM1;
    hdrNow.groupIndex = groupIndex;
    hdrNow.override = override ? tmp_fields_pkg::OVERRIDE_ON : tmp_fields_pkg::OVERRIDE_OFF;
    hdrNow.filtCodeCount = filtCodeCount;
    hdrNow.carrierShift = carrierShift;
    hdrNow.rsv = 6'h3f;
  end

  tmp_fields_pkg::xmtr_t xmtrNow;
  always_comb
  begin
    xmtrNow.stationAddress = xAddr[entryIdx];
    xmtrNow.delayAdjust = xDelay[entryIdx];
    xmtrNow.identSignalLevel = xLevel[entryIdx];
    // slot stored as code minus one
    xmtrNow.filterSlot = xSlot[entryIdx];
    xmtrNow.rsv = 29'h1fffffff;
  end

  // records left aligned and sent MSB first
  wire [95:0] emitWord = {emitSec[entryIdx], emitNs[entryIdx], 32'h0};
  wire [95:0] xmtrWord = {xmtrNow, 32'h0};
  wire [95:0] relWord = {relSec, relSub, 2'b11, 80'h0};
  wire [95:0] chkWord = {payloadCheckWord, 80'h0};
  wire [95:0] recWord = (state == tmp_fields_pkg::S_HDR) ? hdr :
    (state == tmp_fields_pkg::S_EMIT) ? emitWord :
    (state == tmp_fields_pkg::S_XMTR) ? xmtrWord :
    (state == tmp_fields_pkg::S_REL) ? relWord : chkWord;
  wire [3:0] recLen = (state == tmp_fields_pkg::S_HDR) ? tmp_fields_pkg::HDR_BYTES :
    (state == tmp_fields_pkg::S_EMIT || state == tmp_fields_pkg::S_XMTR) ? tmp_fields_pkg::ENTRY_BYTES :
    tmp_fields_pkg::TAIL_BYTES;
  wire [7:0] curByte = topByte(recWord, byteIdx);
  wire recDone = byteIdx == recLen - 4'h1;

  // output register free when empty or being taken
  wire advance = !byteValid || byteReady;
  wire emitting = advance && !isIdle;
  wire packetEnd = emitting && recDone && state == tmp_fields_pkg::S_CHK;

  tmp_fields_pkg::state_t next_state;
  always_comb
  begin
    next_state = state;
    unique case (state)
      tmp_fields_pkg::S_IDLE:
        if (launch)
          next_state = tmp_fields_pkg::S_HDR;
      tmp_fields_pkg::S_HDR:
        if (emitting && recDone)
          next_state = tmp_fields_pkg::S_EMIT;
      tmp_fields_pkg::S_EMIT:
        if (emitting && recDone && entryIdx == hdr.emitCountM1)
          next_state = tmp_fields_pkg::S_XMTR;
      tmp_fields_pkg::S_XMTR:
        if (emitting && recDone && entryIdx == hdr.groupSizeM1)
          next_state = tmp_fields_pkg::S_REL;
      tmp_fields_pkg::S_REL:
        if (emitting && recDone)
          next_state = tmp_fields_pkg::S_CHK;
      tmp_fields_pkg::S_CHK:
        if (packetEnd)
          next_state = tmp_fields_pkg::S_IDLE;
      default:
        next_state = tmp_fields_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      state <= tmp_fields_pkg::S_IDLE;
    else
      state <= next_state;
  end

  // header and release time frozen at launch so mid-packet writes cannot tear them
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      hdr <= '0;
      relSec <= 4'h0;
      relSub <= 10'h0;
    end
    else if (launch)
    begin
      hdr <= hdrNow;
      relSec <= taiSeconds[3:0];
      relSub <= taiNanos[29:20];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn || launch)
    begin
      byteIdx <= 4'h0;
      entryIdx <= 6'h0;
    end
    else if (emitting)
    begin
      byteIdx <= recDone ? 4'h0 : byteIdx + 4'h1;
      if (recDone && next_state != state)
        entryIdx <= 6'h0;
      else if (recDone)
        entryIdx <= entryIdx + 6'h1;
    end
  end

  // group index steps and wraps per packet
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      groupIndex <= 7'h0;
    else if (packetEnd)
      groupIndex <= (groupIndex >= groupLast) ? 7'h0 : groupIndex + 7'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      byteData <= 8'h0;
      byteValid <= 1'b0;
      byteFirst <= 1'b0;
      byteLast <= 1'b0;
      firstPending <= 1'b0;
    end
    else
    begin
      if (launch)
        firstPending <= 1'b1;
      else if (emitting)
        firstPending <= 1'b0;
      if (emitting)
      begin
        byteData <= curByte;
        byteValid <= 1'b1;
        byteFirst <= firstPending;
        byteLast <= packetEnd;
      end
      else if (advance)
      begin
        byteValid <= 1'b0;
        byteFirst <= 1'b0;
        byteLast <= 1'b0;
      end
    end
  end

  // check word over everything before it
  payload_check_crc checkCalc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(launch),
    .enable(emitting && state != tmp_fields_pkg::S_CHK),
    .dataIn(curByte),
    .crc(payloadCheckWord)
  );

  // payload type for the header builder
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      payloadType <= 7'h0;
    else
      payloadType <= tmp_fields_pkg::PAYLOAD_TYPE;
  end

  assign busy = !isIdle;
endmodule : timing_mgmt_packet_framer
